// ==== design/converter_diagnostic_monitor.v ====
// Diagnostic monitor of the converter, reached over AXI4-Lite
//
// Functional notes
// - Reference missing or open sets its flag
// - Reference missing also sets summary bit
// - Conversion checks gated by one enable
// - Filter over/underflow flags and clamps result
// - Twenty equal modulator bits flag fault
// - Bad offset coefficient kept out, flagged
// - Gain calibration overflow flags, keeps gain
// - Fault flag updates with data or calibration, W1C
// - Separate enables per analog input
// - Each input has own range flag
// - Reference range flag from either end
// - Range flags set only when enabled
// - Clock count increments every 131 cycles
// - Clock count wraps at maximum
// - Test signal pair selectable on channel
// - Reference missing clamps output to ones
`timescale 1ns/1ps
`include "diag_monitor_defs.vh"

module converter_diagnostic_monitor (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog comparators, asynchronous
    input wire ref_below_threshold_i,
    input wire ref_open_i,
    input wire pos_input_over_i,
    input wire pos_input_under_i,
    input wire neg_input_over_i,
    input wire neg_input_under_i,
    input wire ref_pos_over_i,
    input wire ref_neg_under_i,
    // Converter core, same clock
    input wire conv_active_i,
    input wire mod_bit_valid_i,
    input wire mod_bit_i,
    input wire data_update_i,
    input wire [15:0] filter_data_i,
    input wire filter_overflow_i,
    input wire filter_underflow_i,
    input wire offset_cal_done_i,
    input wire gain_cal_done_i,
    input wire [15:0] cal_coef_i,
    // Results towards the core
    output reg [15:0] result_o,
    output reg result_valid_o,
    output reg [15:0] offset_coef_o,
    output reg [15:0] gain_coef_o,
    output reg test_signal_select_o
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [7:0] pin_meta_q;
    reg [7:0] pin_sync_q;
    wire [7:0] pin_raw = {ref_neg_under_i, ref_pos_over_i, neg_input_under_i, neg_input_over_i,
                          pos_input_under_i, pos_input_over_i, ref_open_i, ref_below_threshold_i};

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [`EN_WIDTH-1:0] error_en_q;
    reg [`ERR_WIDTH-1:0] error_q;
    reg [`ERR_WIDTH-1:0] error_d;
    reg [31:0] clock_count_q;
    reg [7:0] div_count_q;
    reg [3:0] channel_sel_q;

    // AXI handshakes
    reg [7:0] aw_addr_q;
    reg aw_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_held_q;
    wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    wire [31:0] w1c_mask = (wr_fire && aw_addr_q == `OFF_ERROR && w_strb_q[0]) ? w_data_q : 32'h0000_0000;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q > `OFF_RESULT || aw_addr_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Software controlled registers
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            error_en_q <= `ERROR_EN_RESET;
            channel_sel_q <= 4'h0;
        end else if (wr_fire && w_strb_q[0]) begin
            if (aw_addr_q == `OFF_ERROR_EN) begin
                error_en_q <= w_data_q[`EN_WIDTH-1:0];
            end
            if (aw_addr_q == `OFF_CHANNEL_SEL) begin
                channel_sel_q <= w_data_q[3:0];
            end
        end
    end

    // ----------------------------------------
    // Conversion fault detection
    // ----------------------------------------
    wire run_hit;
    wire conv_check_en = error_en_q[`BIT_CONV_FAULT] && conv_active_i;
    wire offset_bad = cal_coef_i < `OFFSET_MIN || cal_coef_i > `OFFSET_MAX;
    reg sat_pending_q;

    run_length_detector #(
        .RUN_LEN(`SAT_RUN_LEN)
    ) u_run_detect (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .bit_valid_i(mod_bit_valid_i && conv_check_en),
        .bit_i(mod_bit_i),
        .clear_i(!conv_check_en),
        .run_hit_o(run_hit)
    );

    // Saturation is held until the next data update publishes it
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sat_pending_q <= 1'b0;
        end else if (data_update_i) begin
            sat_pending_q <= run_hit;
        end else if (run_hit) begin
            sat_pending_q <= 1'b1;
        end
    end

    wire conv_fault_evt = conv_check_en && (
        (data_update_i && (filter_overflow_i || filter_underflow_i || sat_pending_q || run_hit)) ||
        (offset_cal_done_i && offset_bad) ||
        (gain_cal_done_i && filter_overflow_i));

    // ----------------------------------------
    // Error flags
    // ----------------------------------------
    wire [`ERR_WIDTH-1:0] set_evt;
    assign set_evt[`BIT_REF_MISSING] = error_en_q[`BIT_REF_MISSING] && (pin_sync_q[0] || pin_sync_q[1]);
    assign set_evt[`BIT_CONV_FAULT] = conv_fault_evt;
    assign set_evt[`BIT_POS_INPUT] = error_en_q[`BIT_POS_INPUT] && (pin_sync_q[2] || pin_sync_q[3]);
    assign set_evt[`BIT_NEG_INPUT] = error_en_q[`BIT_NEG_INPUT] && (pin_sync_q[4] || pin_sync_q[5]);
    assign set_evt[`BIT_REF_RANGE] = error_en_q[`BIT_REF_RANGE] && (pin_sync_q[6] || pin_sync_q[7]);

    always @* begin
        error_d = (error_q & ~w1c_mask[`ERR_WIDTH-1:0]) | set_evt;
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            error_q <= {`ERR_WIDTH{1'b0}};
        end else begin
            error_q <= error_d;
        end
    end

    // ----------------------------------------
    // Result path and calibration registers
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            result_o <= `RESULT_ZEROS;
            result_valid_o <= 1'b0;
            offset_coef_o <= `OFFSET_RESET;
            gain_coef_o <= `GAIN_RESET;
            test_signal_select_o <= 1'b0;
        end else begin
            result_valid_o <= data_update_i;
            test_signal_select_o <= channel_sel_q == `SEL_TEST_SIGNAL;
            if (data_update_i) begin
                if (error_d[`BIT_REF_MISSING]) begin
                    result_o <= `RESULT_ONES;
                end else if (conv_check_en && filter_overflow_i) begin
                    result_o <= `RESULT_ZEROS;
                end else if (conv_check_en && filter_underflow_i) begin
                    result_o <= `RESULT_ONES;
                end else begin
                    result_o <= filter_data_i;
                end
            end
            // offset kept when out of range
            if (offset_cal_done_i && !(conv_check_en && offset_bad)) begin
                offset_coef_o <= cal_coef_i;
            end
            if (gain_cal_done_i && !(conv_check_en && filter_overflow_i)) begin
                gain_coef_o <= cal_coef_i;
            end
        end
    end

    // ----------------------------------------
    // Clock counter
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            div_count_q <= 8'h00;
            clock_count_q <= 32'h0000_0000;
        end else if (!error_en_q[`BIT_CLOCK_COUNT]) begin
            div_count_q <= 8'h00;
        end else if ({24'h00_0000, div_count_q} == `CLOCK_DIV_CYCLES - 1) begin
            div_count_q <= 8'h00;
            clock_count_q <= clock_count_q + 32'h0000_0001;
        end else begin
            div_count_q <= div_count_q + 8'h01;
        end
    end

    // ----------------------------------------
    // AXI read path
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `OFF_STATUS: s_axi_rdata <= {31'h0, |error_q};
                    `OFF_ERROR: s_axi_rdata <= {27'h0, error_q};
                    `OFF_ERROR_EN: s_axi_rdata <= {26'h0, error_en_q};
                    `OFF_CLOCK_COUNT: s_axi_rdata <= clock_count_q;
                    `OFF_OFFSET_COEF: s_axi_rdata <= {16'h0, offset_coef_o};
                    `OFF_GAIN_COEF: s_axi_rdata <= {16'h0, gain_coef_o};
                    `OFF_CHANNEL_SEL: s_axi_rdata <= {28'h0, channel_sel_q};
                    `OFF_RESULT: s_axi_rdata <= {16'h0, result_o};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // converter_diagnostic_monitor

// ==== design/diag_monitor_defs.vh ====
// Register map, field positions, reset values and timing counts of the diagnostic monitor
`ifndef DIAG_MONITOR_DEFS_VH
`define DIAG_MONITOR_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_STATUS 8'h00
`define OFF_ERROR 8'h04
`define OFF_ERROR_EN 8'h08
`define OFF_CLOCK_COUNT 8'h0C
`define OFF_OFFSET_COEF 8'h10
`define OFF_GAIN_COEF 8'h14
`define OFF_CHANNEL_SEL 8'h18
`define OFF_RESULT 8'h1C

// ----------------------------------------
// Error and enable bit positions
// ----------------------------------------
`define BIT_REF_MISSING 0
`define BIT_CONV_FAULT 1
`define BIT_POS_INPUT 2
`define BIT_NEG_INPUT 3
`define BIT_REF_RANGE 4
`define BIT_CLOCK_COUNT 5
`define ERR_WIDTH 5
`define EN_WIDTH 6

// Status register fields
`define BIT_SUMMARY 0

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define ERROR_EN_RESET 6'h00
`define OFFSET_RESET 16'h8000
`define GAIN_RESET 16'h5555
`define OFFSET_MIN 16'h07FF
`define OFFSET_MAX 16'hF7FF
`define RESULT_ONES 16'hFFFF
`define RESULT_ZEROS 16'h0000
`define SEL_TEST_SIGNAL 4'hF

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define CLOCK_DIV_CYCLES 131
`define SAT_RUN_LEN 20

`endif

// ==== design/run_length_detector.v ====
// Detects a run of identical modulator bits of a given length
`timescale 1ns/1ps

module run_length_detector #(
    parameter RUN_LEN = 20
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // Bitstream
    input wire bit_valid_i,
    input wire bit_i,
    input wire clear_i,
    // Result
    output reg run_hit_o
);

    reg last_bit_q;
    reg [4:0] run_len_q;

    always @(posedge ref_clk_i) begin
        if (rst_i || clear_i) begin
            last_bit_q <= 1'b0;
            run_len_q <= 5'h00;
            run_hit_o <= 1'b0;
        end else if (bit_valid_i) begin
            last_bit_q <= bit_i;
            if (run_len_q != 5'h00 && bit_i == last_bit_q) begin
                if (run_len_q != RUN_LEN[4:0]) begin
                    run_len_q <= run_len_q + 5'h01;
                end
                run_hit_o <= (run_len_q + 5'h01) == RUN_LEN[4:0];
            end else begin
                run_len_q <= 5'h01;
                run_hit_o <= 1'b0;
            end
        end else begin
            run_hit_o <= 1'b0;
        end
    end

endmodule // run_length_detector

// ==== verif/afe_model.sv ====
// Front end model: range comparators and modulator bitstream
`timescale 1ns/1ps

module afe_model (
    // Clock
    input wire ref_clk_i,
    // Bench commands
    input wire [7:0] fault_i,
    input wire stuck_i,
    // Towards the monitor
    output wire [7:0] cmp_o,
    output reg bit_valid_o = 1'h0,
    output reg bit_o = 1'h0
);
    // ----------------------------------------
    // Comparators and modulator
    // ----------------------------------------
    assign cmp_o = fault_i;
    // stuck runs on demand
    // Toggling otherwise, so a run never forms by accident
    always @(posedge ref_clk_i) begin
        bit_valid_o <= 1'h1;
        bit_o <= stuck_i ? 1'h1 : ~bit_o;
    end
endmodule // afe_model

// ==== verif/diag_checker.sv ====
// Port checks of the diagnostic monitor
`timescale 1ns/1ps
`include "diag_monitor_defs.vh"

module diag_checker (
    input wire ref_clk_i,
    input wire rst_i,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire data_update_i,
    input wire filter_overflow_i,
    input wire filter_underflow_i,
    input wire offset_cal_done_i,
    input wire gain_cal_done_i,
    input wire [15:0] cal_coef_i,
    input wire [15:0] result_o,
    input wire result_valid_o,
    input wire [15:0] offset_coef_o,
    input wire [15:0] gain_coef_o
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence aw_taken;
        s_axi_awready;
    endsequence
    sequence b_within;
        ##[1:4] s_axi_bvalid;
    endsequence
    sequence one_pulse;
        result_valid_o ##1 !result_valid_o;
    endsequence
    write_answer_a: assert property (aw_taken |-> b_within)
        else $error("write response missing");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    result_pulse_a: assert property (data_update_i |=> one_pulse)
        else $error("result valid not one pulse");
    under_clamp_a: assert property (data_update_i && filter_underflow_i && !filter_overflow_i
        |=> result_o == `RESULT_ONES) else $error("underflow not clamped");
    offset_keep_a: assert property (offset_cal_done_i && (cal_coef_i < `OFFSET_MIN
        || cal_coef_i > `OFFSET_MAX) |=> $stable(offset_coef_o)) else $error("bad offset taken");
    gain_keep_a: assert property (gain_cal_done_i && filter_overflow_i
        |=> $stable(gain_coef_o)) else $error("gain taken on overflow");
endmodule // diag_checker

bind converter_diagnostic_monitor diag_checker u_diag_checker (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .data_update_i(data_update_i), .filter_overflow_i(filter_overflow_i),
    .filter_underflow_i(filter_underflow_i), .offset_cal_done_i(offset_cal_done_i),
    .gain_cal_done_i(gain_cal_done_i), .cal_coef_i(cal_coef_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .offset_coef_o(offset_coef_o), .gain_coef_o(gain_coef_o));

// ==== verif/test_converter_diagnostic_monitor.sv ====
// Self-checking bench of the converter diagnostic monitor
`timescale 1ns/1ps
`include "diag_monitor_defs.vh"

module test_converter_diagnostic_monitor;
    reg ref_clk_i, rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg [7:0] s_axi_awaddr, s_axi_araddr, fault;
    reg [31:0] s_axi_wdata, rv;
    reg [3:0] s_axi_wstrb;
    reg [1:0] rr;
    reg conv_active_i, data_update_i, filter_overflow_i, filter_underflow_i, offset_cal_done_i, gain_cal_done_i, stuck;
    reg [15:0] filter_data_i, cal_coef_i;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] result_o, offset_coef_o, gain_coef_o;
    wire result_valid_o, test_signal_select_o, mod_bit_valid_i, mod_bit_i;
    wire ref_below_threshold_i, ref_open_i, pos_input_over_i, pos_input_under_i;
    wire neg_input_over_i, neg_input_under_i, ref_pos_over_i, ref_neg_under_i;
    wire [7:0] cmp;
    integer n_errors = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer i;
    assign {ref_neg_under_i, ref_pos_over_i, neg_input_under_i, neg_input_over_i, pos_input_under_i,
        pos_input_over_i, ref_open_i, ref_below_threshold_i} = cmp;

    converter_diagnostic_monitor u_converter_diagnostic_monitor (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ref_below_threshold_i(ref_below_threshold_i), .ref_open_i(ref_open_i),
        .pos_input_over_i(pos_input_over_i), .pos_input_under_i(pos_input_under_i),
        .neg_input_over_i(neg_input_over_i), .neg_input_under_i(neg_input_under_i),
        .ref_pos_over_i(ref_pos_over_i), .ref_neg_under_i(ref_neg_under_i), .conv_active_i(conv_active_i),
        .mod_bit_valid_i(mod_bit_valid_i), .mod_bit_i(mod_bit_i), .data_update_i(data_update_i),
        .filter_data_i(filter_data_i), .filter_overflow_i(filter_overflow_i),
        .filter_underflow_i(filter_underflow_i), .offset_cal_done_i(offset_cal_done_i),
        .gain_cal_done_i(gain_cal_done_i), .cal_coef_i(cal_coef_i), .result_o(result_o),
        .result_valid_o(result_valid_o), .offset_coef_o(offset_coef_o), .gain_coef_o(gain_coef_o),
        .test_signal_select_o(test_signal_select_o));
    afe_model u_afe_model (.ref_clk_i(ref_clk_i), .fault_i(fault), .stuck_i(stuck), .cmp_o(cmp),
        .bit_valid_o(mod_bit_valid_i), .bit_o(mod_bit_i));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // One register access; address and data stay put until taken
    task acc(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_i);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= w;
            s_axi_wvalid <= w;
            s_axi_bready <= w;
            s_axi_arvalid <= !w;
            s_axi_rready <= !w;
            do begin
                @(posedge ref_clk_i);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!(s_axi_bvalid || s_axi_rvalid));
            s_axi_bready <= 1'h0;
            s_axi_rready <= 1'h0;
            rv = s_axi_rdata;
            rr = w ? s_axi_bresp : s_axi_rresp;
        end
    endtask
    task rc(input string n, input [7:0] a, input [31:0] e);
        begin
            acc(1'h0, a, 32'h0);
            chk(n, e, rv);
        end
    endtask
    // Read the error flags, then clear them all
    task ec(input string n, input [31:0] e);
        begin
            rc(n, `OFF_ERROR, e);
            acc(1'h1, `OFF_ERROR, 32'h1F);
        end
    endtask
    task upd(input o, input u, input [15:0] d);
        begin
            @(posedge ref_clk_i);
            data_update_i <= 1'h1;
            filter_overflow_i <= o;
            filter_underflow_i <= u;
            filter_data_i <= d;
            @(posedge ref_clk_i);
            data_update_i <= 1'h0;
            #1;
        end
    endtask
    task cal(input g, input [15:0] c, input o);
        begin
            @(posedge ref_clk_i);
            offset_cal_done_i <= !g;
            gain_cal_done_i <= g;
            cal_coef_i <= c;
            filter_overflow_i <= o;
            @(posedge ref_clk_i);
            offset_cal_done_i <= 1'h0;
            gain_cal_done_i <= 1'h0;
            filter_overflow_i <= 1'h0;
            #1;
        end
    endtask
    task settle;
        repeat (6) @(posedge ref_clk_i);
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Clock, timeout and tests
    // ----------------------------------------
    initial begin
        ref_clk_i = 1'h0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
            s_axi_rready, data_update_i, filter_overflow_i, filter_underflow_i, offset_cal_done_i,
            gain_cal_done_i, filter_data_i, cal_coef_i, fault, stuck} = 0;
        s_axi_wstrb = 4'hF;
        conv_active_i = 1'h1;
        rst_i = 1'h1;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        rc("offset", `OFF_OFFSET_COEF, 32'h8000);
        rc("gain", `OFF_GAIN_COEF, 32'h5555);
        rc("enable", `OFF_ERROR_EN, 32'h0);
        rc("unmapped", 8'h20, 32'h0);
        chk("rresp", 32'h2, {30'h0, rr});
        acc(1'h1, 8'h24, 32'h1);
        chk("bresp", 32'h2, {30'h0, rr});
        $display("test reset done");
        acc(1'h1, `OFF_ERROR_EN, 32'h1C);
        for (i = 2; i < 8; i = i + 1) begin
            fault <= 8'h01 << i;
            settle;
            fault <= 8'h0;
            settle;
            ec("range", 32'h01 << (i / 2 + 1));
        end
        acc(1'h1, `OFF_ERROR_EN, 32'h04);
        fault <= 8'hFC;
        settle;
        fault <= 8'h0;
        settle;
        ec("pos only", 32'h04);
        rc("cleared", `OFF_ERROR, 32'h0);
        $display("test range done");
        acc(1'h1, `OFF_ERROR_EN, 32'h01);
        for (i = 0; i < 2; i = i + 1) begin
            fault <= 8'h01 << i;
            settle;
            fault <= 8'h0;
            rc("summary", `OFF_STATUS, 32'h1);
            upd(1'h0, 1'h0, 16'h1234);
            chk("clamp", 32'hFFFF, {16'h0, result_o});
            settle;
            ec("ref", 32'h01);
        end
        upd(1'h0, 1'h0, 16'h1234);
        chk("plain", 32'h1234, {16'h0, result_o});
        upd(1'h1, 1'h0, 16'h1234);
        ec("gated", 32'h0);
        $display("test reference done");
        acc(1'h1, `OFF_ERROR_EN, 32'h02);
        upd(1'h1, 1'h0, 16'h1234);
        chk("overflow", 32'h0, {16'h0, result_o});
        chk("valid", 32'h1, {31'h0, result_valid_o});
        ec("ovf flag", 32'h02);
        conv_active_i <= 1'h0;
        upd(1'h1, 1'h0, 16'h1234);
        chk("idle pass", 32'h1234, {16'h0, result_o});
        conv_active_i <= 1'h1;
        ec("idle", 32'h0);
        upd(1'h0, 1'h1, 16'h1234);
        chk("underflow", 32'hFFFF, {16'h0, result_o});
        ec("unf flag", 32'h02);
        for (i = 0; i < 2; i = i + 1) begin
            stuck <= 1'h1;
            repeat (10 + i * 15) @(posedge ref_clk_i);
            stuck <= 1'h0;
            upd(1'h0, 1'h0, 16'h1234);
            ec("saturation", i * 2);
        end
        cal(1'h0, 16'hF800, 1'h0);
        chk("off keep", 32'h8000, {16'h0, offset_coef_o});
        ec("off high", 32'h02);
        cal(1'h0, 16'hF7FF, 1'h0);
        chk("off take", 32'hF7FF, {16'h0, offset_coef_o});
        cal(1'h0, 16'h07FE, 1'h0);
        chk("off low", 32'hF7FF, {16'h0, offset_coef_o});
        ec("off low", 32'h02);
        cal(1'h1, 16'h1111, 1'h1);
        chk("gain keep", 32'h5555, {16'h0, gain_coef_o});
        ec("gain flag", 32'h02);
        cal(1'h1, 16'h1111, 1'h0);
        chk("gain take", 32'h1111, {16'h0, gain_coef_o});
        $display("test conversion done");
        acc(1'h1, `OFF_CHANNEL_SEL, {28'h0, `SEL_TEST_SIGNAL});
        settle;
        chk("test sig", 32'h1, {31'h0, test_signal_select_o});
        acc(1'h1, `OFF_CHANNEL_SEL, 32'h0);
        settle;
        chk("no test", 32'h0, {31'h0, test_signal_select_o});
        acc(1'h1, `OFF_ERROR_EN, 32'h20);
        repeat (`CLOCK_DIV_CYCLES * 4 + 65) @(posedge ref_clk_i);
        acc(1'h1, `OFF_ERROR_EN, 32'h0);
        rc("count", `OFF_CLOCK_COUNT, 32'h4);
        $display("test misc done");
        close_out;
    end
endmodule // test_converter_diagnostic_monitor
